// ===== src/phy_vendor_debug_pkg.sv
// constants for the vendor debug register bank of the 10/100 transceiver
package phy_vendor_debug_pkg;

	// register bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [4:0] REG_PCS_CONTROL = 5'h10;
	localparam logic [4:0] REG_ARBITER_STATE = 5'h11;
	localparam logic [4:0] REG_PULSE_MACHINE_STATE = 5'h12;
	localparam logic [4:0] REG_USER_OUTPUT_WORD = 5'h14;
	localparam logic [4:0] REG_RECEIVE_ERROR_COUNTER = 5'h15;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h16;
	localparam logic [4:0] REG_IRQ_MASK = 5'h17;

	// pcs control field positions
	localparam int PCS_LOCK_BIT = 15;
	localparam int PCS_UNUSED_MSB = 14;
	localparam int PCS_UNUSED_LSB = 12;
	localparam int PCS_TEST_MSB = 11;
	localparam int PCS_TEST_LSB = 4;
	localparam int PCS_LOOP_CFG_BIT = 3;
	localparam int PCS_SCAN_BIT = 2;
	localparam int PCS_FORCE_LOOP_BIT = 1;
	localparam int PCS_SPEEDUP_BIT = 0;

	// field widths
	localparam int ARB_STATE_W = 13;
	localparam int NLP_STATE_W = 6;
	localparam int FLP_XMIT_W = 6;
	localparam int FLP_RCV_ACTIVE_W = 4;
	localparam int IRQ_W = 4;

	// error counter packing
	localparam int CNT_MODE_BIT = 0;
	localparam int CNT8_RXER_W = 8;
	localparam int CNT8_FALSE_W = 4;
	localparam int CNT8_DISC_W = 4;

	// interrupt bit positions
	localparam int IRQ_RXER_BIT = 0;
	localparam int IRQ_FALSE_BIT = 1;
	localparam int IRQ_DISC_BIT = 2;
	localparam int IRQ_LOCK_LOST_BIT = 3;

	// reset values
	localparam logic [15:0] PCS_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] USER_WORD_RESET = 16'h0000;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam logic CNT_MODE_RESET = 1'b0;

	// link monitor interval
	localparam int CLK_MHZ = 50;
	localparam int LM_NORMAL_US = 620;
	localparam int LM_FAST_US = 10;
	localparam int LM_NORMAL_CYCLES = LM_NORMAL_US * CLK_MHZ;
	localparam int LM_FAST_CYCLES = LM_FAST_US * CLK_MHZ;
	localparam int LM_CNT_W = 16;

endpackage : phy_vendor_debug_pkg

// ===== src/sat_event_counter.sv
// saturating event counter with clear that never loses a same-cycle event
`timescale 1ns/100ps
`default_nettype none

module sat_event_counter #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic inc,
	output logic [W-1:0] count
);

	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	wire logic at_top = &count_r;

	// an event in the clearing cycle becomes the first count of the new window
	assign count_nxt = clr ? {{(W-1){1'b0}}, inc} : ((inc && !at_top) ? count_r + 1'b1 : count_r);
	assign count = count_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

endmodule : sat_event_counter

`default_nettype wire

// ===== src/link_monitor_timer.sv
// link monitor interval timer, restarted whenever the monitor is idle
`timescale 1ns/100ps
`default_nettype none

module link_monitor_timer #(
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic [CW-1:0] interval,
	output logic done
);

	logic [CW-1:0] cnt_r;
	logic done_r;
	wire logic expire = run && (cnt_r >= interval - 1'b1);

	// comparing with >= lets a shortened interval take effect mid-count
	always_ff @(posedge clk)
	begin
		if (sys_rst || !run || expire)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			done_r <= 1'b0;
		else
			done_r <= expire;
	end

	assign done = done_r;

endmodule : link_monitor_timer

`default_nettype wire

// ===== src/phy_vendor_debug_registers.sv
// vendor debug register bank: pcs control, autoneg state views, user word, error counters
//
// Behaviour
// - The top bit of pcs control reads the live descrambler lock indication.
// - The three bits below the lock bit in pcs control always read zero.
// - The eight generic test bits are stored read/write and do not steer the pcs; software should write zero.
// - With loopback configure set the whole loopback runs inside the pcs, otherwise loopback only disables collision.
// - Force loopback loops data back without forcing transmit idle and without disabling collision.
// - Counter speedup shortens the link monitor interval from 620 us to 10 us, the same as quick test mode.
// - The arbiter state register shows the arbitration states in its low bits and reads zero in its top three.
// - Top bit of the pulse machine register is set while FLP receive is in capture, clock, data-zero or data-one.
// - Each normal link pulse receive state is shown as its own read-only bit.
// - Each FLP transmit state is shown as its own read-only bit in the lowest six bits.
// - A write-only mode bit selects 16-bit packing at zero and 8-bit packing at one, resets to zero, never reads.
// - In 16-bit packing all sixteen bits count receive errors and a read clears them.
// - In 8-bit packing the low byte counts receive errors and a read clears it.
// - In 8-bit packing the next four bits count false carrier events and a read clears them.
// - In 8-bit packing the top four bits count disconnect events and a read clears them.
`timescale 1ns/100ps
`default_nettype none

module phy_vendor_debug_registers
	import phy_vendor_debug_pkg::*;
#(
	parameter int LM_NORMAL_CNT = phy_vendor_debug_pkg::LM_NORMAL_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [phy_vendor_debug_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [phy_vendor_debug_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [phy_vendor_debug_pkg::DATA_W-1:0] reg_rdata,
	input wire logic descrambler_locked,
	input wire logic loopback_req,
	input wire logic quick_test_mode,
	input wire logic link_monitor_run,
	input wire logic [phy_vendor_debug_pkg::ARB_STATE_W-1:0] arbiter_state,
	input wire logic [phy_vendor_debug_pkg::FLP_RCV_ACTIVE_W-1:0] flp_rcv_active_states,
	input wire logic flp_rcv_pass,
	input wire logic flp_rcv_pulse_count,
	input wire logic flp_rcv_pulse_detect,
	input wire logic [phy_vendor_debug_pkg::NLP_STATE_W-1:0] nlp_rcv_state,
	input wire logic [phy_vendor_debug_pkg::FLP_XMIT_W-1:0] flp_xmit_state,
	input wire logic rx_error_evt,
	input wire logic false_carrier_evt,
	input wire logic disconnect_evt,
	output logic pcs_loop_active,
	output logic tx_force_idle,
	output logic collision_disable,
	output logic scan_mode,
	output logic [7:0] generic_test_field,
	output logic link_monitor_done,
	output logic [15:0] user_word_out_bus,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	wire logic sel_pcs = (reg_addr == REG_PCS_CONTROL);
	wire logic sel_arb = (reg_addr == REG_ARBITER_STATE);
	wire logic sel_pulse = (reg_addr == REG_PULSE_MACHINE_STATE);
	wire logic sel_user = (reg_addr == REG_USER_OUTPUT_WORD);
	wire logic sel_cnt = (reg_addr == REG_RECEIVE_ERROR_COUNTER);
	wire logic sel_isr = (reg_addr == REG_IRQ_STATUS);
	wire logic sel_imr = (reg_addr == REG_IRQ_MASK);
	wire logic wr_pcs = reg_wr && sel_pcs;
	wire logic wr_user = reg_wr && sel_user;
	wire logic wr_cnt = reg_wr && sel_cnt;
	wire logic wr_isr = reg_wr && sel_isr;
	wire logic wr_imr = reg_wr && sel_imr;
	wire logic rd_cnt = reg_rd && sel_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// writable state

	logic [11:0] pcs_ctl_r;
	logic [15:0] user_word_r;
	logic cnt_mode_r;
	logic [IRQ_W-1:0] irq_status_r;
	logic [IRQ_W-1:0] irq_status_nxt;
	logic [IRQ_W-1:0] irq_mask_r;
	logic locked_prev_r;
	logic [DATA_W-1:0] rdata_r;

	// only bits 11..0 hold state; the lock and unused bits are live or constant
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pcs_ctl_r <= PCS_CONTROL_RESET[11:0];
		else if (wr_pcs)
			pcs_ctl_r <= reg_wdata[11:0];
	end

	// user word goes straight to the output bus
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			user_word_r <= USER_WORD_RESET;
		else if (wr_user)
			user_word_r <= reg_wdata;
	end

	// packing mode is write-only; reads of this offset see the counters
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cnt_mode_r <= CNT_MODE_RESET;
		else if (wr_cnt)
			cnt_mode_r <= reg_wdata[CNT_MODE_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// pcs control effects

	wire logic loop_cfg = pcs_ctl_r[PCS_LOOP_CFG_BIT];
	wire logic force_loop = pcs_ctl_r[PCS_FORCE_LOOP_BIT];
	wire logic speedup = pcs_ctl_r[PCS_SPEEDUP_BIT];

	// force loopback overrides the idle and collision side effects of plain loopback
	assign pcs_loop_active = force_loop || (loopback_req && loop_cfg);
	assign tx_force_idle = loopback_req && loop_cfg && !force_loop;
	assign collision_disable = loopback_req && !force_loop;
	assign scan_mode = pcs_ctl_r[PCS_SCAN_BIT];
	assign generic_test_field = pcs_ctl_r[PCS_TEST_MSB:PCS_TEST_LSB];
	assign user_word_out_bus = user_word_r;

	////////////////////////////////////////////////////////////////////////////////
	// link monitor interval

	localparam logic [LM_CNT_W-1:0] LM_NORMAL_VAL = LM_CNT_W'(LM_NORMAL_CNT);
	localparam logic [LM_CNT_W-1:0] LM_FAST_VAL = LM_CNT_W'(LM_FAST_CYCLES);

	wire logic lm_fast = speedup || quick_test_mode;
	wire logic [LM_CNT_W-1:0] lm_interval = lm_fast ? LM_FAST_VAL : LM_NORMAL_VAL;

	link_monitor_timer #(
		.CW(LM_CNT_W)
	) u_lm_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(link_monitor_run),
		.interval(lm_interval),
		.done(link_monitor_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// event counters

	logic [15:0] cnt16_rxer;
	logic [CNT8_RXER_W-1:0] cnt8_rxer;
	logic [CNT8_FALSE_W-1:0] cnt8_false;
	logic [CNT8_DISC_W-1:0] cnt8_disc;

	// only the counters of the selected packing advance; a read clears them all
	wire logic inc16_rxer = rx_error_evt && !cnt_mode_r;
	wire logic inc8_rxer = rx_error_evt && cnt_mode_r;
	wire logic inc8_false = false_carrier_evt && cnt_mode_r;
	wire logic inc8_disc = disconnect_evt && cnt_mode_r;

	sat_event_counter #(
		.W(16)
	) u_cnt16_rxer (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr(rd_cnt),
		.inc(inc16_rxer),
		.count(cnt16_rxer)
	);

	sat_event_counter #(
		.W(CNT8_RXER_W)
	) u_cnt8_rxer (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr(rd_cnt),
		.inc(inc8_rxer),
		.count(cnt8_rxer)
	);

	sat_event_counter #(
		.W(CNT8_FALSE_W)
	) u_cnt8_false (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr(rd_cnt),
		.inc(inc8_false),
		.count(cnt8_false)
	);

	sat_event_counter #(
		.W(CNT8_DISC_W)
	) u_cnt8_disc (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr(rd_cnt),
		.inc(inc8_disc),
		.count(cnt8_disc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// interrupts

	wire logic lock_lost_evt = locked_prev_r && !descrambler_locked;
	wire logic [IRQ_W-1:0] irq_events = {lock_lost_evt, disconnect_evt, false_carrier_evt, rx_error_evt};
	wire logic [IRQ_W-1:0] irq_clear = wr_isr ? reg_wdata[IRQ_W-1:0] : '0;

	// a new event wins over a write-one-to-clear in the same cycle
	assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_events;
	assign irq = |(irq_status_r & irq_mask_r);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_status_r <= '0;
			irq_mask_r <= IRQ_MASK_RESET;
			locked_prev_r <= 1'b0;
		end
		else
		begin
			irq_status_r <= irq_status_nxt;
			irq_mask_r <= wr_imr ? reg_wdata[IRQ_W-1:0] : irq_mask_r;
			locked_prev_r <= descrambler_locked;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	wire logic [15:0] pcs_view = {descrambler_locked, 3'h0, pcs_ctl_r};
	wire logic [15:0] arb_view = {3'h0, arbiter_state};
	wire logic flp_receiving = |flp_rcv_active_states;
	wire logic [15:0] pulse_view = {flp_receiving, flp_rcv_pass, flp_rcv_pulse_count, flp_rcv_pulse_detect,
		nlp_rcv_state, flp_xmit_state};
	wire logic [15:0] cnt_view = cnt_mode_r ? {cnt8_disc, cnt8_false, cnt8_rxer} : cnt16_rxer;
	wire logic [15:0] isr_view = {12'h000, irq_status_r};
	wire logic [15:0] imr_view = {12'h000, irq_mask_r};

	// unmapped offsets read as zero
	wire logic [15:0] rd_mux = sel_pcs ? pcs_view :
		sel_arb ? arb_view :
		sel_pulse ? pulse_view :
		sel_user ? user_word_r :
		sel_cnt ? cnt_view :
		sel_isr ? isr_view :
		sel_imr ? imr_view : 16'h0000;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst || !reg_rd)
			rdata_r <= '0;
		else
			rdata_r <= rd_mux;
	end

	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_lock_live;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_pcs) |=> (reg_rdata[15] == $past(descrambler_locked));
	endproperty
	a_lock_live: assert property (p_lock_live) else $error("lock bit does not follow descrambler");

	property p_unused_zero;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_pcs) |=> (reg_rdata[14:12] == 3'h0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused pcs bits not zero");

	property p_test_bits;
		@(posedge clk) disable iff (sys_rst)
		wr_pcs |=> (generic_test_field == $past(reg_wdata[PCS_TEST_MSB:PCS_TEST_LSB]));
	endproperty
	a_test_bits: assert property (p_test_bits) else $error("test bits not stored");

	property p_loop_cfg_low;
		@(posedge clk) disable iff (sys_rst)
		(loopback_req && !loop_cfg && !force_loop) |-> (collision_disable && !pcs_loop_active && !tx_force_idle);
	endproperty
	a_loop_cfg_low: assert property (p_loop_cfg_low) else $error("plain loopback does more than disable collision");

	property p_force_loop;
		@(posedge clk) disable iff (sys_rst)
		(wr_pcs && reg_wdata[PCS_FORCE_LOOP_BIT]) |=> (pcs_loop_active && !tx_force_idle && !collision_disable);
	endproperty
	a_force_loop: assert property (p_force_loop) else $error("force loopback has side effects");

	property p_fast_interval;
		@(posedge clk) disable iff (sys_rst)
		($rose(link_monitor_run) && lm_fast) ##1 (link_monitor_run && lm_fast) [*8] |-> ##[0:495] link_monitor_done;
	endproperty
	a_fast_interval: assert property (p_fast_interval) else $error("fast link monitor interval too long");

	property p_arb_top_zero;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_arb) |=> (reg_rdata == {3'h0, $past(arbiter_state)});
	endproperty
	a_arb_top_zero: assert property (p_arb_top_zero) else $error("arbiter view wrong");

	property p_flp_receiving;
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_pulse) |=> (reg_rdata[15] == ($past(flp_rcv_active_states) != 4'h0));
	endproperty
	a_flp_receiving: assert property (p_flp_receiving) else $error("receiving flp bit wrong");

	property p_user_hold;
		@(posedge clk) disable iff (sys_rst)
		wr_user ##1 !wr_user |-> (user_word_out_bus == $past(reg_wdata));
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("user word bus lost its value");

	property p_mode_select;
		@(posedge clk) disable iff (sys_rst)
		wr_cnt |=> (cnt_mode_r == $past(reg_wdata[0]));
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("packing mode not taken");

	property p_clear_on_read;
		@(posedge clk) disable iff (sys_rst)
		(rd_cnt && !rx_error_evt) |=> (cnt16_rxer == 16'h0000 && cnt8_rxer == 8'h00);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("counter not cleared by read");

	property p_saturate;
		@(posedge clk) disable iff (sys_rst)
		(cnt8_disc == 4'hF && !rd_cnt) |=> (cnt8_disc == 4'hF);
	endproperty
	a_saturate: assert property (p_saturate) else $error("disconnect count wrapped");

endmodule : phy_vendor_debug_registers

`default_nettype wire

// ===== verification/mgmt_station_model.sv
// management station model: turns one request into a one-cycle register strobe
`timescale 1ns/100ps
`default_nettype none

module mgmt_station_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic go_wr,
	input wire logic [phy_vendor_debug_pkg::ADDR_W-1:0] go_addr,
	input wire logic [phy_vendor_debug_pkg::DATA_W-1:0] go_data,
	input wire logic [phy_vendor_debug_pkg::DATA_W-1:0] reg_rdata,
	output logic [phy_vendor_debug_pkg::ADDR_W-1:0] reg_addr,
	output logic [phy_vendor_debug_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [phy_vendor_debug_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_done
);
	import phy_vendor_debug_pkg::*;

	logic rd_pend_r;

	// strobe lasts one cycle; idle bus inverts its last value each cycle, so stale values come back on every second idle cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			rd_pend_r <= 1'b0;
			rsp_done <= 1'b0;
			reg_addr <= 5'h00;
			reg_wdata <= 16'h0000;
		end
		else
		begin
			reg_wr <= go & go_wr;
			reg_rd <= go & ~go_wr;
			rd_pend_r <= reg_rd;
			rsp_done <= reg_wr | rd_pend_r;
			reg_addr <= go ? go_addr : ~reg_addr;
			reg_wdata <= go ? go_data : ~reg_wdata;
			if (rd_pend_r)
				rsp_data <= reg_rdata; // data only valid the cycle after the read strobe
		end
	end

endmodule : mgmt_station_model

`default_nettype wire

// ===== verification/test_phy_vendor_debug_registers.sv
// self-checking testbench for the vendor debug register bank
`timescale 1ns/100ps
`default_nettype none

module test_phy_vendor_debug_registers;
	import phy_vendor_debug_pkg::*;

	// short normal interval keeps the run brief; must stay above the fast one
	localparam int LM_SMALL = 1000;

	logic clk, sys_rst, go, go_wr, reg_wr, reg_rd, rsp_done;
	logic [4:0] go_addr, reg_addr;
	logic [15:0] go_data, reg_wdata, reg_rdata, rsp_data, user_word_out_bus;
	logic descrambler_locked, loopback_req, quick_test_mode, link_monitor_run;
	logic [12:0] arbiter_state;
	logic [3:0] flp_act;
	logic flp_pass, flp_cnt, flp_det, rx_evt, fc_evt, dc_evt;
	logic [5:0] nlp_st, xmit_st;
	logic pcs_loop_active, tx_force_idle, collision_disable, scan_mode, link_monitor_done, irq;
	logic [7:0] generic_test_field;
	int err_total, cmp_count;

	phy_vendor_debug_registers #(.LM_NORMAL_CNT(LM_SMALL)) uut (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.descrambler_locked(descrambler_locked), .loopback_req(loopback_req),
		.quick_test_mode(quick_test_mode), .link_monitor_run(link_monitor_run),
		.arbiter_state(arbiter_state), .flp_rcv_active_states(flp_act), .flp_rcv_pass(flp_pass),
		.flp_rcv_pulse_count(flp_cnt), .flp_rcv_pulse_detect(flp_det), .nlp_rcv_state(nlp_st),
		.flp_xmit_state(xmit_st), .rx_error_evt(rx_evt), .false_carrier_evt(fc_evt),
		.disconnect_evt(dc_evt), .pcs_loop_active(pcs_loop_active), .tx_force_idle(tx_force_idle),
		.collision_disable(collision_disable), .scan_mode(scan_mode),
		.generic_test_field(generic_test_field), .link_monitor_done(link_monitor_done),
		.user_word_out_bus(user_word_out_bus), .irq(irq));

	mgmt_station_model mgmt (.clk(clk), .sys_rst(sys_rst), .go(go), .go_wr(go_wr), .go_addr(go_addr),
		.go_data(go_data), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .rsp_data(rsp_data), .rsp_done(rsp_done));

	////////////////////////////////////////////////////////////////////////////
	// clock and watchdog; the tests need roughly 6k cycles
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		#(20 * 50000);
		err_total++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// compare, bus and stimulus helpers
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic bus_op(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		go <= 1'b1;
		go_wr <= wr;
		go_addr <= a;
		go_data <= d;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (rsp_done !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
		begin
			err_total++;
			$display("mismatch at %0t: bus answer %h expected %h", $time, rsp_done, 1'b1);
		end
		q = rsp_data;
		@(posedge clk);
	endtask : bus_op

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus_op(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] q;
		bus_op(1'b0, a, 16'h0000, q);
		check(q, exp);
	endtask : rd_chk

	// events as separated one-cycle pulses, m = {disconnect, false carrier, rx error}
	task automatic evts(input int n, input logic [2:0] m);
		repeat (n)
		begin
			{dc_evt, fc_evt, rx_evt} <= m;
			@(posedge clk);
			{dc_evt, fc_evt, rx_evt} <= 3'b000;
			@(posedge clk);
		end
	endtask : evts

	// cycles between two consecutive interval pulses
	task automatic period_chk(input int exp);
		int n;
		n = 0;
		while (link_monitor_done !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		n = 1;
		while (link_monitor_done !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		check(16'(n), 16'(exp));
	endtask : period_chk

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		{go, go_wr, go_addr, go_data} = '0;
		{descrambler_locked, loopback_req, quick_test_mode, link_monitor_run} = 4'b1001;
		{arbiter_state, flp_act, flp_pass, flp_cnt, flp_det, nlp_st, xmit_st} = '0;
		{rx_evt, fc_evt, dc_evt} = 3'b000;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		// lock bit live, unused bits zero, test bits stored
		rd_chk(5'h10, 16'h8000);
		descrambler_locked <= 1'b0;
		wr(5'h10, 16'hFFF4);
		rd_chk(5'h10, 16'h0FF4);
		check({8'h00, generic_test_field}, 16'h00FF);
		check({15'h0000, scan_mode}, 16'h0001);
		descrambler_locked <= 1'b1;
		wr(5'h10, 16'h0000);
		rd_chk(5'h10, 16'h8000);
		// every combination of configure, force and request
		for (int i = 0; i < 8; i++)
		begin
			wr(5'h10, {12'h000, i[0], 1'b0, i[1], 1'b0});
			loopback_req <= i[2];
			@(posedge clk);
			check({13'h0000, pcs_loop_active, tx_force_idle, collision_disable}, {13'h0000, i[1] | (i[2] & i[0]),
				i[2] & i[0] & ~i[1], i[2] & ~i[1]});
		end
		loopback_req <= 1'b0;
		// link monitor interval: normal, speedup bit, quick test mode
		wr(5'h10, 16'h0000);
		period_chk(LM_SMALL);
		wr(5'h10, 16'h0001);
		period_chk(LM_FAST_CYCLES);
		wr(5'h10, 16'h0000);
		quick_test_mode <= 1'b1;
		period_chk(LM_FAST_CYCLES);
		// restart the monitor while fast so the first interval after a start is watched too
		link_monitor_run <= 1'b0;
		repeat (2) @(posedge clk);
		link_monitor_run <= 1'b1;
		period_chk(LM_FAST_CYCLES);
		quick_test_mode <= 1'b0;
		// state views are read-only and placed bit for bit
		arbiter_state <= 13'h1A5C;
		wr(5'h11, 16'hFFFF);
		rd_chk(5'h11, 16'h1A5C);
		for (int i = 0; i < 5; i++)
		begin
			flp_act <= 4'(i < 4 ? (1 << i) : 0);
			{flp_pass, flp_cnt, flp_det} <= 3'(i + 1);
			nlp_st <= 6'h2D;
			xmit_st <= 6'h13;
			wr(5'h12, 16'h0000);
			rd_chk(5'h12, {(i < 4) ? 1'b1 : 1'b0, 3'(i + 1), 6'h2D, 6'h13});
		end
		// user word drives the bus and reads back
		wr(5'h14, 16'hA5C3);
		rd_chk(5'h14, 16'hA5C3);
		check(user_word_out_bus, 16'hA5C3);
		rd_chk(5'h13, 16'h0000);
		// 16-bit packing counts only rx errors, read clears
		rd_chk(5'h15, 16'h0000);
		evts(5, 3'b111);
		rd_chk(5'h15, 16'h0005);
		rd_chk(5'h15, 16'h0000);
		// 8-bit packing with saturation of the disconnect and rx error fields
		wr(5'h15, 16'h0001);
		evts(3, 3'b001);
		evts(2, 3'b010);
		evts(20, 3'b100);
		rd_chk(5'h15, 16'hF203);
		evts(300, 3'b001);
		rd_chk(5'h15, 16'h00FF);
		rd_chk(5'h15, 16'h0000);
		// sticky status, mask and level interrupt; lock loss was seen earlier
		rd_chk(5'h16, 16'h000F);
		check({15'h0000, irq}, 16'h0000);
		wr(5'h17, 16'h0001);
		rd_chk(5'h17, 16'h0001);
		check({15'h0000, irq}, 16'h0001);
		wr(5'h16, 16'h0001);
		check({15'h0000, irq}, 16'h0000);
		rd_chk(5'h16, 16'h000E);
		stop_test();
	end

endmodule : test_phy_vendor_debug_registers

`default_nettype wire
